// ==== pkg/asc_consts.svh ====
// Purpose: constants of the converter configuration port
// Assumes: 8-bit registers, 12-bit addresses, 24-bit frames
// Notes: shared by the package and the top module
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// ****************************************
// frame layout
// ****************************************
`define ASC_FRAME_BITS 24
`define ASC_BIT_LAST 5'h17
`define ASC_BIT_ADDR_DONE 5'h0f
`define ASC_BIT_DATA_FIRST 5'h10

// ****************************************
// register offsets
// ****************************************
`define ASC_ADDR_SOFT_RESET 12'h000
`define ASC_ADDR_OUT_IF 12'h007
`define ASC_ADDR_PDN_MAIN 12'h008
`define ASC_ADDR_PDN_DRV 12'h009
`define ASC_ADDR_PDN_MASK 12'h00d
`define ASC_ADDR_REF_CTRL 12'h00e
`define ASC_ADDR_FUSE_LOAD 12'h013
`define ASC_ADDR_PAT_LOW 12'h014
`define ASC_ADDR_PAT_MID 12'h015
`define ASC_ADDR_PAT_SEL 12'h016
`define ASC_ADDR_DEC_EN 12'h024
`define ASC_ADDR_DEC_CFG 12'h025
`define ASC_ADDR_MIXER 12'h026
`define ASC_ADDR_FMT_A 12'h08f
`define ASC_ADDR_FMT_B 12'h092

// ****************************************
// field positions
// ****************************************
`define ASC_POS_SOFT_RESET 0
`define ASC_POS_PDN_GLOBAL 0
`define ASC_POS_PDN_ADC 2
`define ASC_POS_PDN_REFAMP 4
`define ASC_POS_PDN_CLKBUF 5
`define ASC_POS_MASK_INTREF 1
`define ASC_POS_MASK_REFAMP 2
`define ASC_POS_MASK_CLKBUF 3
`define ASC_POS_INTREF_EN 3
`define ASC_POS_FUSE_LOAD 0
`define ASC_POS_DEC_EN 1
`define ASC_POS_FORMAT 1
`define ASC_POS_PAT_A 2
`define ASC_POS_PAT_HI 0

// ****************************************
// reset values
// ****************************************
`define ASC_RST_REG 8'h00
`define ASC_RST_OUT_IF_SLOW 8'h00
`define ASC_RST_OUT_IF_FAST 8'h01
`define ASC_RST_PDN 11'h501

// ****************************************
// test pattern codes
// ****************************************
`define ASC_PAT_NORMAL 3'h0
`define ASC_PAT_RAMP 3'h1
`define ASC_PAT_CUSTOM 3'h2

`endif

// ==== pkg/asc_pkg.sv ====
// Purpose: types of the converter configuration port
// Assumes: constants come from asc_consts.svh
// Notes: nothing here is imported; names are written in full
`include "asc_consts.svh"

package asc_pkg;

	typedef struct packed {
		logic rw;
		logic [2:0] zero;
		logic [11:0] addr;
		logic [7:0] data;
	} asc_frame_t;

	typedef struct packed {
		logic [7:0] out_if;
		logic [7:0] pdn_main;
		logic [7:0] pdn_drv;
		logic [7:0] pdn_mask;
		logic [7:0] ref_ctrl;
		logic [7:0] fuse_load;
		logic [7:0] pat_low;
		logic [7:0] pat_mid;
		logic [7:0] pat_sel;
		logic [7:0] dec_en;
		logic [7:0] dec_cfg;
		logic [7:0] mixer;
		logic [7:0] fmt_a;
		logic [7:0] fmt_b;
	} asc_regs_t;

	typedef struct packed {
		logic adc;
		logic refamp;
		logic intref;
		logic clkbuf;
		logic [5:0] drivers;
		logic decim;
	} asc_pdn_t;

	typedef enum logic [2:0] {
		ASC_PAT_NORMAL = `ASC_PAT_NORMAL,
		ASC_PAT_RAMP = `ASC_PAT_RAMP,
		ASC_PAT_CUSTOM = `ASC_PAT_CUSTOM
	} asc_pat_t;

endpackage

// ==== core/asc_top.sv ====
// Purpose: serial configuration port, test pattern, format and power-down control
// Assumes: serial_clk is the controller's clock, idle between frames
// Notes: register reads cross as quasi-static data, stable between writes
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_top #(
	parameter bit FAST_GRADE = 1'b0,
	parameter int DATA_W = 18
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic serial_clk,
	input wire logic serial_enable_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	input wire logic powerdown_sync_pin,
	input wire logic conv_clk_present,
	input wire logic [DATA_W-1:0] conv_data_a,
	input wire logic [DATA_W-1:0] conv_data_b,
	input wire logic conv_valid,
	output logic [DATA_W-1:0] sample_a,
	output logic [DATA_W-1:0] sample_b,
	output logic sample_valid,
	output asc_pkg::asc_pdn_t pdn,
	output logic fuse_load,
	output logic [7:0] out_if_cfg,
	output logic [7:0] dec_en_cfg,
	output logic [7:0] dec_cfg,
	output logic [7:0] mixer_cfg
);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [DATA_W-1:0] fmt_code(input logic [DATA_W-1:0] v, input logic ob);
		fmt_code = ob ? {~v[DATA_W-1], v[DATA_W-2:0]} : v;
	endfunction

	// masked blocks ignore the global request
	function automatic logic masked_pd(input logic own, input logic g, input logic mask);
		masked_pd = own | (g & ~mask);
	endfunction

	function automatic asc_pkg::asc_regs_t regs_default();
		asc_pkg::asc_regs_t r;
		r = '0;
		r.out_if = FAST_GRADE ? `ASC_RST_OUT_IF_FAST : `ASC_RST_OUT_IF_SLOW;
		regs_default = r;
	endfunction

	function automatic logic [7:0] reg_read(input asc_pkg::asc_regs_t r, input logic [11:0] a);
		unique case (a)
			`ASC_ADDR_OUT_IF: reg_read = r.out_if;
			`ASC_ADDR_PDN_MAIN: reg_read = r.pdn_main;
			`ASC_ADDR_PDN_DRV: reg_read = r.pdn_drv;
			`ASC_ADDR_PDN_MASK: reg_read = r.pdn_mask;
			`ASC_ADDR_REF_CTRL: reg_read = r.ref_ctrl;
			`ASC_ADDR_FUSE_LOAD: reg_read = r.fuse_load;
			`ASC_ADDR_PAT_LOW: reg_read = r.pat_low;
			`ASC_ADDR_PAT_MID: reg_read = r.pat_mid;
			`ASC_ADDR_PAT_SEL: reg_read = r.pat_sel;
			`ASC_ADDR_DEC_EN: reg_read = r.dec_en;
			`ASC_ADDR_DEC_CFG: reg_read = r.dec_cfg;
			`ASC_ADDR_MIXER: reg_read = r.mixer;
			`ASC_ADDR_FMT_A: reg_read = r.fmt_a;
			`ASC_ADDR_FMT_B: reg_read = r.fmt_b;
			default: reg_read = `ASC_RST_REG;
		endcase
	endfunction

	// ****************************************
	// link side: receive on rising edges
	// ****************************************
	logic [4:0] bit_cnt_q, bit_cnt_d;
	logic [22:0] shift_q, shift_d;
	logic rd_q, rd_d;
	logic [11:0] rd_addr_q, rd_addr_d;
	logic word_done;
	asc_pkg::asc_frame_t frame;

	always_comb begin
		frame = {shift_q, sdio_in};
		word_done = (bit_cnt_q == `ASC_BIT_LAST);
		shift_d = {shift_q[21:0], sdio_in};
		bit_cnt_d = word_done ? 5'h00 : bit_cnt_q + 5'h01;
		rd_d = rd_q;
		rd_addr_d = rd_addr_q;
		if (bit_cnt_q == `ASC_BIT_ADDR_DONE) begin
			rd_d = shift_q[14];
			rd_addr_d = {shift_q[10:0], sdio_in};
		end
	end

	// enable high clears the partial frame; clock may stop outside frames
	always_ff @(posedge serial_clk or posedge serial_enable_n) begin
		if (serial_enable_n) begin
			bit_cnt_q <= 5'h00;
			shift_q <= 23'h000000;
			rd_q <= 1'b0;
			rd_addr_q <= 12'h000;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			rd_q <= rd_d;
			rd_addr_q <= rd_addr_d;
		end
	end

	// ****************************************
	// link side: hand write words to the core
	// ****************************************
	asc_pkg::asc_frame_t wr_word_q, wr_word_d;
	logic wr_tgl_q, wr_tgl_d;

	always_comb begin
		wr_word_d = wr_word_q;
		wr_tgl_d = wr_tgl_q;
		if (!serial_enable_n && word_done && !frame.rw) begin
			wr_word_d = frame;
			wr_tgl_d = ~wr_tgl_q;
		end
	end

	always_ff @(posedge serial_clk or negedge resetn) begin
		if (!resetn) begin
			wr_word_q <= '0;
			wr_tgl_q <= 1'b0;
		end else begin
			wr_word_q <= wr_word_d;
			wr_tgl_q <= wr_tgl_d;
		end
	end

	// ****************************************
	// link side: readback on falling edges
	// ****************************************
	asc_pkg::asc_regs_t regs_q, regs_d;
	logic sdio_out_d, sdio_oe_n_d;
	logic [7:0] rd_byte;
	logic [2:0] rd_idx;

	always_comb begin
		rd_byte = reg_read(regs_q, rd_addr_q);
		rd_idx = 3'(`ASC_BIT_LAST - bit_cnt_q);
		sdio_out_d = 1'b0;
		sdio_oe_n_d = 1'b1;
		if (rd_q && bit_cnt_q >= `ASC_BIT_DATA_FIRST) begin
			sdio_out_d = rd_byte[rd_idx];
			sdio_oe_n_d = 1'b0;
		end
	end

	always_ff @(negedge serial_clk or posedge serial_enable_n) begin
		if (serial_enable_n) begin
			sdio_out <= 1'b0;
			sdio_oe_n <= 1'b1;
		end else begin
			sdio_out <= sdio_out_d;
			sdio_oe_n <= sdio_oe_n_d;
		end
	end

	// ****************************************
	// core side: crossings
	// ****************************************
	logic [2:0] tgl_sync_q, tgl_sync_d;
	logic [1:0] pin_sync_q, pin_sync_d;
	logic [1:0] clk_sync_q, clk_sync_d;
	logic wr_evt;

	always_comb begin
		tgl_sync_d = {tgl_sync_q[1:0], wr_tgl_q};
		pin_sync_d = {pin_sync_q[0], powerdown_sync_pin};
		clk_sync_d = {clk_sync_q[0], conv_clk_present};
		wr_evt = tgl_sync_q[2] ^ tgl_sync_q[1];
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tgl_sync_q <= 3'h0;
			pin_sync_q <= 2'h0;
			clk_sync_q <= 2'h0;
		end else begin
			tgl_sync_q <= tgl_sync_d;
			pin_sync_q <= pin_sync_d;
			clk_sync_q <= clk_sync_d;
		end
	end

	// ****************************************
	// core side: register file
	// ****************************************
	always_comb begin
		regs_d = regs_q;
		if (wr_evt) begin
			unique case (wr_word_q.addr)
				`ASC_ADDR_SOFT_RESET: begin
					if (wr_word_q.data[`ASC_POS_SOFT_RESET]) begin
						regs_d = regs_default();
					end
				end
				`ASC_ADDR_OUT_IF: regs_d.out_if = wr_word_q.data;
				`ASC_ADDR_PDN_MAIN: regs_d.pdn_main = wr_word_q.data;
				`ASC_ADDR_PDN_DRV: regs_d.pdn_drv = wr_word_q.data;
				`ASC_ADDR_PDN_MASK: regs_d.pdn_mask = wr_word_q.data;
				`ASC_ADDR_REF_CTRL: regs_d.ref_ctrl = wr_word_q.data;
				`ASC_ADDR_FUSE_LOAD: regs_d.fuse_load = wr_word_q.data;
				`ASC_ADDR_PAT_LOW: regs_d.pat_low = wr_word_q.data;
				`ASC_ADDR_PAT_MID: regs_d.pat_mid = wr_word_q.data;
				`ASC_ADDR_PAT_SEL: regs_d.pat_sel = wr_word_q.data;
				`ASC_ADDR_DEC_EN: regs_d.dec_en = wr_word_q.data;
				`ASC_ADDR_DEC_CFG: regs_d.dec_cfg = wr_word_q.data;
				`ASC_ADDR_MIXER: regs_d.mixer = wr_word_q.data;
				`ASC_ADDR_FMT_A: regs_d.fmt_a = wr_word_q.data;
				`ASC_ADDR_FMT_B: regs_d.fmt_b = wr_word_q.data;
				default: regs_d = regs_q;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			regs_q <= regs_default();
		end else begin
			regs_q <= regs_d;
		end
	end

	// ****************************************
	// core side: power-down
	// ****************************************
	asc_pkg::asc_pdn_t pdn_d;
	logic glob;

	always_comb begin
		glob = regs_q.pdn_main[`ASC_POS_PDN_GLOBAL] | pin_sync_q[1];
		pdn_d = pdn;
		if (clk_sync_q[1]) begin
			pdn_d.adc = regs_q.pdn_main[`ASC_POS_PDN_ADC] | glob;
			pdn_d.refamp = masked_pd(regs_q.pdn_main[`ASC_POS_PDN_REFAMP], glob,
				regs_q.pdn_mask[`ASC_POS_MASK_REFAMP]);
			pdn_d.clkbuf = masked_pd(regs_q.pdn_main[`ASC_POS_PDN_CLKBUF], glob,
				regs_q.pdn_mask[`ASC_POS_MASK_CLKBUF]);
			pdn_d.intref = masked_pd(~regs_q.ref_ctrl[`ASC_POS_INTREF_EN], glob,
				regs_q.pdn_mask[`ASC_POS_MASK_INTREF]);
			pdn_d.drivers = regs_q.pdn_drv[5:0];
			pdn_d.decim = ~regs_q.dec_en[`ASC_POS_DEC_EN];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pdn <= `ASC_RST_PDN;
		end else begin
			pdn <= pdn_d;
		end
	end

	// ****************************************
	// core side: test pattern and format
	// ****************************************
	logic [DATA_W-1:0] ramp_q, ramp_d;
	logic [DATA_W-1:0] user_pat;
	logic [DATA_W-1:0] sample_a_d, sample_b_d, raw_a, raw_b;
	asc_pkg::asc_pat_t pat_mode;

	always_comb begin
		user_pat = DATA_W'({regs_q.pat_sel[1:0], regs_q.pat_mid, regs_q.pat_low});
		pat_mode = asc_pkg::asc_pat_t'(regs_q.pat_sel[`ASC_POS_PAT_A +: 3]);
		ramp_d = ramp_q;
		raw_a = conv_data_a;
		raw_b = conv_data_b;
		unique case (pat_mode)
			asc_pkg::ASC_PAT_RAMP: begin
				if (conv_valid) begin
					ramp_d = ramp_q + user_pat;
				end
				raw_a = ramp_q;
				raw_b = ramp_q;
			end
			asc_pkg::ASC_PAT_CUSTOM: begin
				raw_a = user_pat;
				raw_b = user_pat;
			end
			default: begin
				ramp_d = '0;
			end
		endcase
		sample_a_d = fmt_code(raw_a, regs_q.fmt_a[`ASC_POS_FORMAT]);
		sample_b_d = fmt_code(raw_b, regs_q.fmt_b[`ASC_POS_FORMAT]);
		// samples hold between valid strobes
		if (!conv_valid) begin
			sample_a_d = sample_a;
			sample_b_d = sample_b;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ramp_q <= '0;
			sample_a <= '0;
			sample_b <= '0;
			sample_valid <= 1'b0;
		end else begin
			ramp_q <= ramp_d;
			sample_valid <= conv_valid;
			sample_a <= sample_a_d;
			sample_b <= sample_b_d;
		end
	end

	// ****************************************
	// core side: configuration outputs
	// ****************************************
	logic fuse_load_d;
	logic [7:0] out_if_cfg_d, dec_en_cfg_d, dec_cfg_d, mixer_cfg_d;

	// one flip-flop between register file and pins
	always_comb begin
		fuse_load_d = regs_q.fuse_load[`ASC_POS_FUSE_LOAD];
		out_if_cfg_d = regs_q.out_if;
		dec_en_cfg_d = regs_q.dec_en;
		dec_cfg_d = regs_q.dec_cfg;
		mixer_cfg_d = regs_q.mixer;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fuse_load <= 1'b0;
			out_if_cfg <= 8'h00;
			dec_en_cfg <= 8'h00;
			dec_cfg <= 8'h00;
			mixer_cfg <= 8'h00;
		end else begin
			fuse_load <= fuse_load_d;
			out_if_cfg <= out_if_cfg_d;
			dec_en_cfg <= dec_en_cfg_d;
			dec_cfg <= dec_cfg_d;
			mixer_cfg <= mixer_cfg_d;
		end
	end

endmodule

// ==== sim/asc_checker.sv ====
// Purpose: pin level checks of the configuration port
// Assumes: serial clock stands still outside frames
// Notes: bound to every asc_top
`timescale 1ns/1ps

module asc_checker #(
	parameter int DATA_W = 18
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic serial_clk,
	input wire logic serial_enable_n,
	input wire logic sdio_in,
	input wire logic sdio_oe_n,
	input wire logic powerdown_sync_pin,
	input wire logic conv_clk_present,
	input wire logic conv_valid,
	input wire logic [DATA_W-1:0] sample_a,
	input wire logic [DATA_W-1:0] sample_b,
	input wire logic sample_valid,
	input wire asc_pkg::asc_pdn_t pdn,
	input wire logic fuse_load,
	input wire logic [7:0] dec_cfg,
	input wire logic [7:0] mixer_cfg
);
	// bits seen in the current word, and its rw bit
	logic [4:0] cnt_q;
	logic rw_q;
	always_ff @(posedge serial_clk or posedge serial_enable_n) begin
		if (serial_enable_n) begin
			cnt_q <= 5'h00;
			rw_q <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == 5'h17) ? 5'h00 : cnt_q + 5'h01;
			if (cnt_q == 5'h00) begin
				rw_q <= sdio_in;
			end
		end
	end
	sequence s_pin_held;
		(powerdown_sync_pin && conv_clk_present) [*5];
	endsequence
	sequence s_clk_gone;
		!conv_clk_present [*4];
	endsequence
	chk_valid_follow: assert property (@(posedge core_clk) disable iff (!resetn)
		conv_valid |=> sample_valid) else $error("sample_valid missing");
	chk_sample_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		!conv_valid |=> !sample_valid && $stable(sample_a) && $stable(sample_b))
		else $error("samples moved without valid");
	chk_oe_idle: assert property (@(posedge core_clk) disable iff (!resetn)
		serial_enable_n |-> sdio_oe_n) else $error("data line driven while idle");
	chk_oe_early: assert property (@(posedge serial_clk) disable iff (serial_enable_n)
		(cnt_q < 5'h10 || !rw_q) |-> sdio_oe_n) else $error("data line driven early");
	chk_oe_read: assert property (@(posedge serial_clk) disable iff (serial_enable_n)
		(cnt_q >= 5'h10 && rw_q) |-> !sdio_oe_n) else $error("readback not driven");
	chk_pin_pdn: assert property (@(posedge core_clk) disable iff (!resetn)
		s_pin_held |-> pdn.adc) else $error("pin power-down ignored");
	chk_pdn_frozen: assert property (@(posedge core_clk) disable iff (!resetn)
		s_clk_gone |=> $stable(pdn)) else $error("power-down moved without clock");
	chk_cfg_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		serial_enable_n [*8] |-> $stable(dec_cfg) && $stable(mixer_cfg) && $stable(fuse_load))
		else $error("register changed outside a word");
endmodule

bind asc_top asc_checker #(.DATA_W(DATA_W)) u_asc_checker (.core_clk(core_clk),
	.resetn(resetn), .serial_clk(serial_clk), .serial_enable_n(serial_enable_n),
	.sdio_in(sdio_in), .sdio_oe_n(sdio_oe_n), .powerdown_sync_pin(powerdown_sync_pin),
	.conv_clk_present(conv_clk_present), .conv_valid(conv_valid), .sample_a(sample_a),
	.sample_b(sample_b), .sample_valid(sample_valid), .pdn(pdn), .fuse_load(fuse_load),
	.dec_cfg(dec_cfg), .mixer_cfg(mixer_cfg));

// ==== sim/asc_host_model.sv ====
// Purpose: serial controller on the configuration pins
// Assumes: 125 ns serial clock, 40 percent high, stopped between frames
// Notes: a released data line shows the inverse of the last driven bit
`timescale 1ns/1ps

module asc_host_model (
	output logic serial_clk,
	output logic serial_enable_n,
	output wire logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe_n
);
	logic drv = 1'b1;
	logic rel = 1'b0;
	assign sdio_in = !sdio_oe_n ? sdio_out : (rel ? !drv : drv);
	initial begin
		serial_clk = 1'b0;
		serial_enable_n = 1'b0;
		#2 serial_enable_n = 1'b1;
	end
	// n bits msb first from w[n-1]; q holds the last eight bits seen
	task automatic xfer(input logic [47:0] w, input int n, input logic rdf,
		output logic [7:0] q);
		q = 8'h00;
		#0.1 serial_enable_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#37.3;
			rel = rdf && (i % 24 < 8);
			if (!rel) begin
				drv = w[i];
			end
			#37.9 serial_clk = 1'b1;
			q = {q[6:0], sdio_in};
			#49.8 serial_clk = 1'b0;
		end
		#37.5 serial_enable_n = 1'b1;
		rel = 1'b0;
	endtask
endmodule

// ==== sim/adc_serial_config_control_bench.sv ====
// Purpose: self-checking bench of the configuration port
// Assumes: slow grade, controller model on the serial pins
// Notes: sample inputs and valid change on the falling core clock edge
`timescale 1ns/1ps

module adc_serial_config_control_bench;
	typedef struct packed {
		logic [11:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} asc_row_t;
	logic core_clk = 1'b0;
	logic resetn = 1'b1;
	logic pd_pin = 1'b0;
	logic pres = 1'b1;
	logic cv = 1'b0;
	logic [17:0] da = 18'h00000;
	logic [17:0] db = 18'h00000;
	logic [17:0] sa, sb, v;
	logic ser_clk, enable_n, sdi, sdo, oe_n, sv, fuse;
	logic [7:0] out_if, dec_en, dec, mix, r;
	asc_pkg::asc_pdn_t pdn;
	int failures = 0;
	int num_checks = 0;
	asc_row_t rows[14] = '{'{12'h007, 8'h6c, 8'h6c}, '{12'h009, 8'h3f, 8'h3f},
		'{12'h00e, 8'h08, 8'h08}, '{12'h013, 8'h01, 8'h01}, '{12'h013, 8'h00, 8'h00},
		'{12'h014, 8'h5a, 8'h5a}, '{12'h015, 8'ha5, 8'ha5}, '{12'h016, 8'h03, 8'h03},
		'{12'h024, 8'h06, 8'h06}, '{12'h025, 8'h30, 8'h30}, '{12'h026, 8'haa, 8'haa},
		'{12'h026, 8'h88, 8'h88}, '{12'h0ff, 8'h77, 8'h00}, '{12'h000, 8'h00, 8'h00}};

	always #4 core_clk = ~core_clk;

	asc_top u_asc_top (.core_clk(core_clk), .resetn(resetn), .serial_clk(ser_clk),
		.serial_enable_n(enable_n), .sdio_in(sdi), .sdio_out(sdo), .sdio_oe_n(oe_n),
		.powerdown_sync_pin(pd_pin), .conv_clk_present(pres), .conv_data_a(da),
		.conv_data_b(db), .conv_valid(cv), .sample_a(sa), .sample_b(sb), .sample_valid(sv),
		.pdn(pdn), .fuse_load(fuse), .out_if_cfg(out_if), .dec_en_cfg(dec_en),
		.dec_cfg(dec), .mixer_cfg(mix));
	asc_host_model u_asc_host_model (.serial_clk(ser_clk), .serial_enable_n(enable_n),
		.sdio_in(sdi), .sdio_out(sdo), .sdio_oe_n(oe_n));

	task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk18(input string s, input logic [17:0] e, input logic [17:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		@(negedge core_clk);
		u_asc_host_model.xfer({28'h0000000, a, d}, 24, 1'b0, q);
		repeat (8) @(negedge core_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] q;
		@(negedge core_clk);
		u_asc_host_model.xfer({24'h000000, 4'h8, a, 8'h00}, 24, 1'b1, q);
		chk8("readback", e, q);
	endtask
	task automatic smp(input logic [17:0] a, b, ea, eb);
		@(negedge core_clk);
		da = a;
		db = b;
		cv = 1'b1;
		@(negedge core_clk);
		cv = 1'b0;
		chk18("sample_a", ea, sa);
		chk18("sample_b", eb, sb);
	endtask
	task automatic results;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		failures++;
		results();
	end

	initial begin
		#1 resetn = 1'b0;
		repeat (4) @(negedge core_clk);
		resetn = 1'b1;
		repeat (8) @(negedge core_clk);
		chk18("pdn", 18'h00101, {7'h00, pdn});
		chk8("out_if_cfg", 8'h00, out_if);
		rd(12'h007, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		chk8("out_if_cfg", 8'h6c, out_if);
		chk18("pdn", 18'h0007e, {7'h00, pdn});
		chk8("dec_en_cfg", 8'h06, dec_en);
		chk8("dec_cfg", 8'h30, dec);
		chk8("mixer_cfg", 8'h88, mix);
		wr(12'h013, 8'h01);
		chk8("fuse_load", 8'h01, {7'h00, fuse});
		wr(12'h013, 8'h00);
		chk8("fuse_load", 8'h00, {7'h00, fuse});
		u_asc_host_model.xfer(48'h0025f, 20, 1'b0, r);
		u_asc_host_model.xfer(48'h0014a1_0015b2, 48, 1'b0, r);
		u_asc_host_model.xfer(48'h8025ff, 24, 1'b1, r);
		rd(12'h025, 8'h30);
		rd(12'h014, 8'ha1);
		rd(12'h015, 8'hb2);
		smp(18'h20000, 18'h1ffff, 18'h20000, 18'h1ffff);
		wr(12'h08f, 8'h02);
		wr(12'h092, 8'h02);
		smp(18'h20000, 18'h1ffff, 18'h00000, 18'h3ffff);
		smp(18'h00000, 18'h00000, 18'h20000, 18'h20000);
		wr(12'h08f, 8'h00);
		wr(12'h092, 8'h00);
		wr(12'h016, 8'h0b);
		smp(18'h00001, 18'h00002, 18'h3b2a1, 18'h3b2a1);
		wr(12'h014, 8'h10);
		wr(12'h015, 8'h00);
		wr(12'h016, 8'h04);
		cv = 1'b1;
		@(negedge core_clk);
		v = sa;
		@(negedge core_clk);
		cv = 1'b0;
		chk18("ramp_first", 18'h00000, v);
		chk18("ramp_a", v + 18'h00010, sa);
		chk18("ramp_b", v + 18'h00010, sb);
		chk18("ramp_low", 18'h00000, {14'h0000, v[3:0]});
		wr(12'h000, 8'h01);
		rd(12'h025, 8'h00);
		rd(12'h000, 8'h00);
		chk8("out_if_cfg", 8'h00, out_if);
		chk18("pdn", 18'h00101, {7'h00, pdn});
		pres = 1'b0;
		pd_pin = 1'b1;
		repeat (20) @(negedge core_clk);
		chk18("pdn", 18'h00101, {7'h00, pdn});
		pres = 1'b1;
		repeat (10) @(negedge core_clk);
		chk18("pdn", 18'h00781, {7'h00, pdn});
		wr(12'h00d, 8'h0c);
		chk18("pdn", 18'h00501, {7'h00, pdn});
		pd_pin = 1'b0;
		wr(12'h008, 8'h01);
		chk18("pdn", 18'h00501, {7'h00, pdn});
		resetn = 1'b0;
		repeat (4) @(negedge core_clk);
		resetn = 1'b1;
		repeat (8) @(negedge core_clk);
		chk18("pdn", 18'h00101, {7'h00, pdn});
		chk8("out_if_cfg", 8'h00, out_if);
		rd(12'h00d, 8'h00);
		results();
	end
endmodule
